//--- src/vpsc_regs.vh
`ifndef VPSC_REGS_VH
`define VPSC_REGS_VH

// ==========================================
// register offsets (byte addresses)
`define VPSC_OFS_CTRL 8'h00
`define VPSC_OFS_HFIRST 8'h04
`define VPSC_OFS_HLAST 8'h08
`define VPSC_OFS_VFIRST 8'h0c
`define VPSC_OFS_VLAST 8'h10
`define VPSC_OFS_STATUS 8'h14
`define VPSC_OFS_POS 8'h18

// ==========================================
// control and status field positions
`define VPSC_CTRL_ENC 0
`define VPSC_CTRL_MASTER 1
`define VPSC_CTRL_L625 2
`define VPSC_CTRL_UNIP 3
`define VPSC_CTRL_FMT_MSB 7
`define VPSC_CTRL_FMT_LSB 4
`define VPSC_STAT_ERR 3

// ==========================================
// reset values
`define VPSC_CTRL_RST 8'h02
`define VPSC_HFIRST_RST 10'h000
`define VPSC_HLAST_RST 10'h2cf
`define VPSC_VFIRST_RST 10'h000
`define VPSC_VLAST_RST 10'h0f2

// ==========================================
// format codes and sample values
`define VPSC_FMT_CODES 4'h0
`define VPSC_FMT_MUX 4'h2
`define VPSC_CHROMA_OFS 8'h80
`define VPSC_BLANK_Y 8'h10
`define VPSC_CODE_FF 8'hff
`define VPSC_CODE_00 8'h00

// ==========================================
// picture and line timing counts (pixel clock bytes / lines)
`define VPSC_MAX_H 10'h2d0
`define VPSC_MAX_V_525 10'h0f3
`define VPSC_MAX_V_625 10'h120
`define VPSC_LINE_LEN_525 11'h6b4
`define VPSC_LINE_LEN_625 11'h6c0
`define VPSC_ACT_BYTES 11'h5a0
`define VPSC_LINES_525 10'h20d
`define VPSC_LINES_625 10'h271
`define VPSC_F2_START_525 10'h107
`define VPSC_F2_START_625 10'h139
`define VPSC_VBL_525 10'h013
`define VPSC_VBL_625 10'h018

`endif

//--- src/vpsc_tcode.v
`timescale 1ns/1ps
`default_nettype none
`include "vpsc_regs.vh"

module vpsc_tcode (
	input wire clk,
	input wire rst_b,
	input wire en,
	input wire [7:0] din,
	output reg hit_r,
	output reg err_r,
	output reg f_r,
	output reg v_r,
	output reg h_r
);

	reg [1:0] st_r;
	wire [7:0] expect_w;

	// ==========================================
	// protection bits recomputed from flags
	assign expect_w = {1'b1, din[6], din[5], din[4], din[5] ^ din[4], din[6] ^ din[4],
		din[6] ^ din[5], din[6] ^ din[5] ^ din[4]};

	// ==========================================
	// preamble hunt and flag capture
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= 2'h0;
			hit_r <= 1'b0;
			err_r <= 1'b0;
			f_r <= 1'b0;
			v_r <= 1'b1;
			h_r <= 1'b1;
		end else begin
			hit_r <= 1'b0;
			err_r <= 1'b0;
			if (en) begin
				if (st_r == 2'h3) begin
					st_r <= 2'h0;
					if (din == expect_w) begin
						hit_r <= 1'b1;
						f_r <= din[6];
						v_r <= din[5];
						h_r <= din[4];
					end else begin
						err_r <= 1'b1;
					end
				end else if (din == `VPSC_CODE_FF) begin
					st_r <= 2'h1;
				end else if (st_r != 2'h0 && din == `VPSC_CODE_00) begin
					st_r <= st_r + 2'h1;
				end else begin
					st_r <= 2'h0;
				end
			end
		end
	end

endmodule
`default_nettype wire

//--- src/vpsc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "vpsc_regs.vh"

module vpsc_top (
	input wire CORE_CLK,
	input wire RST_B,
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output wire [31:0] HRDATA,
	output wire HREADYOUT,
	output wire HRESP,
	input wire PIXEL_SAMPLE_CLOCK,
	input wire [7:0] VID_DATA_I,
	output wire [7:0] VID_DATA_O,
	output wire VID_DATA_OE,
	input wire HSYNC_I,
	output wire HSYNC_O,
	output wire HSYNC_OE,
	input wire VSYNC_I,
	output wire VSYNC_O,
	output wire VSYNC_OE,
	input wire FIELD_I,
	output wire FIELD_O,
	output wire FIELD_OE,
	output wire PORT_DIRECTION_PIN,
	output wire ACT_VALID,
	output wire [7:0] ACT_DATA,
	output wire ACT_CHROMA,
	input wire [7:0] DEC_DATA,
	output wire DEC_TAKE
);

	// ==========================================
	// helpers
	function [7:0] conv;
		input [7:0] b;
		input unip;
		begin
			conv = unip ? (b ^ `VPSC_CHROMA_OFS) : b;
		end
	endfunction

	function [7:0] tc_byte;
		input f;
		input v;
		input h;
		begin
			tc_byte = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
		end
	endfunction

	// ==========================================
	// register file and bus state
	reg [7:0] ctrl_r;
	reg [9:0] hf_r, hl_r, vf_r, vl_r;
	reg err_r;
	reg wr_pend_r, rd_pend_r;
	reg [7:0] addr_r;
	reg [31:0] hrdata_r;
	reg [31:0] rd_val;
	wire take_w;
	wire wr_now;

	wire port_direction_pin = ctrl_r[`VPSC_CTRL_ENC];
	wire mst = ctrl_r[`VPSC_CTRL_MASTER];
	wire l625 = ctrl_r[`VPSC_CTRL_L625];
	wire unip = ctrl_r[`VPSC_CTRL_UNIP];
	wire [3:0] fmt = ctrl_r[`VPSC_CTRL_FMT_MSB:`VPSC_CTRL_FMT_LSB];

	// ==========================================
	// pin synchronisers and pixel enable
	reg pc_s1, pc_s2, pc_s3;
	reg [7:0] din_s1, din_s2;
	reg hs_s1, hs_s2, vs_s1, vs_s2, fd_s1, fd_s2;
	wire pix_en = pc_s2 & ~pc_s3;

	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pc_s1 <= 1'b0;
			pc_s2 <= 1'b0;
			pc_s3 <= 1'b0;
			din_s1 <= 8'h00;
			din_s2 <= 8'h00;
			hs_s1 <= 1'b0;
			hs_s2 <= 1'b0;
			vs_s1 <= 1'b0;
			vs_s2 <= 1'b0;
			fd_s1 <= 1'b0;
			fd_s2 <= 1'b0;
		end else begin
			pc_s1 <= PIXEL_SAMPLE_CLOCK;
			pc_s2 <= pc_s1;
			pc_s3 <= pc_s2;
			din_s1 <= VID_DATA_I;
			din_s2 <= din_s1;
			hs_s1 <= HSYNC_I;
			hs_s2 <= hs_s1;
			vs_s1 <= VSYNC_I;
			vs_s2 <= vs_s1;
			fd_s1 <= FIELD_I;
			fd_s2 <= fd_s1;
		end
	end

	// ==========================================
	// timing source selection
	wire fmt_codes = (fmt == `VPSC_FMT_CODES);
	wire fmt_mux = (fmt == `VPSC_FMT_MUX);
	wire fmt_ok = fmt_codes | fmt_mux;
	wire use_gen = (mst & ~port_direction_pin & fmt_ok) | (mst & fmt_mux) | (~port_direction_pin & fmt_codes);
	wire use_code = fmt_codes & port_direction_pin & mst;
	wire use_pin = fmt_ok & ~use_gen & ~use_code;

	// ==========================================
	// embedded code decoder
	wire tc_hit, tc_err, tc_f, tc_v, tc_h;

	vpsc_tcode u_tcode (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.en(pix_en & use_code),
		.din(din_s2),
		.hit_r(tc_hit),
		.err_r(tc_err),
		.f_r(tc_f),
		.v_r(tc_v),
		.h_r(tc_h)
	);

	// ==========================================
	// standard timing generator
	reg [10:0] gen_hcnt_r;
	reg [9:0] gen_line_r;
	wire [10:0] line_len = l625 ? `VPSC_LINE_LEN_625 : `VPSC_LINE_LEN_525;
	wire [9:0] frame_lines = l625 ? `VPSC_LINES_625 : `VPSC_LINES_525;
	wire [9:0] f2_start = l625 ? `VPSC_F2_START_625 : `VPSC_F2_START_525;
	wire [9:0] vbl = l625 ? `VPSC_VBL_625 : `VPSC_VBL_525;
	wire [10:0] hblk = line_len - `VPSC_ACT_BYTES;
	wire gen_h = (gen_hcnt_r < hblk);
	wire gen_f = (gen_line_r >= f2_start);
	wire gen_v = (gen_line_r <= vbl) | (gen_f & (gen_line_r < f2_start + vbl));

	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			gen_hcnt_r <= 11'h000;
			gen_line_r <= 10'h001;
		end else if (pix_en & use_gen) begin
			if (gen_hcnt_r >= line_len - 11'h001) begin
				gen_hcnt_r <= 11'h000;
				gen_line_r <= (gen_line_r >= frame_lines) ? 10'h001 : gen_line_r + 10'h001;
			end else begin
				gen_hcnt_r <= gen_hcnt_r + 11'h001;
			end
		end
	end

	// ==========================================
	// unified sync levels and window tracking
	wire src_h = use_gen ? gen_h : use_code ? tc_h : use_pin ? hs_s2 : 1'b1;
	wire src_v = use_gen ? gen_v : use_code ? tc_v : use_pin ? vs_s2 : 1'b1;
	wire src_f = use_gen ? gen_f : use_code ? tc_f : use_pin ? fd_s2 : 1'b0;
	reg blank_prev_r, new_fld_r, ph_r;
	reg [9:0] hpos_r, vline_r;
	wire sol = blank_prev_r & ~src_h;
	wire [9:0] vnext = new_fld_r ? 10'h000 : vline_r + 10'h001;
	wire [9:0] cur_h = sol ? 10'h000 : hpos_r;
	wire [9:0] cur_v = sol ? vnext : vline_r;
	wire [9:0] maxv = l625 ? `VPSC_MAX_V_625 : `VPSC_MAX_V_525;
	wire is_chroma = sol | ~ph_r;
	wire in_win = ~src_h & ~src_v & (cur_h >= hf_r) & (cur_h <= hl_r)
		& (cur_h < `VPSC_MAX_H) & (cur_v >= vf_r) & (cur_v <= vl_r) & (cur_v < maxv);

	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			blank_prev_r <= 1'b1;
			new_fld_r <= 1'b1;
			ph_r <= 1'b0;
			hpos_r <= 10'h000;
			vline_r <= 10'h000;
		end else if (pix_en) begin
			blank_prev_r <= src_h;
			if (src_v) begin
				new_fld_r <= 1'b1;
			end
			if (src_h) begin
				ph_r <= ~ph_r;
			end else if (sol) begin
				hpos_r <= 10'h000;
				ph_r <= 1'b1;
				if (!src_v) begin
					vline_r <= vnext;
					new_fld_r <= 1'b0;
				end
			end else begin
				ph_r <= ~ph_r;
				if (ph_r && hpos_r != 10'h3ff) begin
					hpos_r <= hpos_r + 10'h001;
				end
			end
		end
	end

	// ==========================================
	// encode path and decode path
	reg act_valid_r, act_chroma_r;
	reg [7:0] act_data_r, vid_o_r;
	reg hs_o_r, vs_o_r, fd_o_r;
	wire ins_codes = use_gen & fmt_codes;
	wire at_eav = (gen_hcnt_r <= 11'h003);
	wire at_sav = (gen_hcnt_r >= hblk - 11'h004) & gen_h;
	wire [1:0] code_pos = gen_hcnt_r[1:0];
	reg [7:0] code_byte;

	always @* begin
		case (code_pos)
			2'h0: code_byte = `VPSC_CODE_FF;
			2'h1: code_byte = `VPSC_CODE_00;
			2'h2: code_byte = `VPSC_CODE_00;
			default: code_byte = tc_byte(gen_f, gen_v, at_eav);
		endcase
	end

	assign DEC_TAKE = pix_en & ~port_direction_pin & in_win;

	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			act_valid_r <= 1'b0;
			act_chroma_r <= 1'b0;
			act_data_r <= 8'h00;
			vid_o_r <= 8'h00;
			hs_o_r <= 1'b1;
			vs_o_r <= 1'b1;
			fd_o_r <= 1'b0;
		end else begin
			act_valid_r <= 1'b0;
			if (pix_en) begin
				if (port_direction_pin && in_win) begin
					act_valid_r <= 1'b1;
					act_chroma_r <= is_chroma;
					act_data_r <= is_chroma ? conv(din_s2, unip) : din_s2;
				end
				if (!port_direction_pin) begin
					if (ins_codes && (at_eav || at_sav)) begin
						vid_o_r <= code_byte;
					end else if (in_win) begin
						vid_o_r <= is_chroma ? conv(DEC_DATA, unip) : DEC_DATA;
					end else begin
						vid_o_r <= is_chroma ? `VPSC_CHROMA_OFS : `VPSC_BLANK_Y;
					end
				end
				if (use_code) begin
					hs_o_r <= tc_h;
					vs_o_r <= tc_v;
					fd_o_r <= tc_f;
				end else if (use_gen) begin
					hs_o_r <= gen_h;
					vs_o_r <= gen_v;
					fd_o_r <= gen_f;
				end
			end
		end
	end

	assign ACT_VALID = act_valid_r;
	assign ACT_DATA = act_data_r;
	assign ACT_CHROMA = act_chroma_r;
	assign VID_DATA_O = vid_o_r;
	assign VID_DATA_OE = ~port_direction_pin;
	assign PORT_DIRECTION_PIN = port_direction_pin;
	assign HSYNC_O = hs_o_r;
	assign VSYNC_O = vs_o_r;
	assign FIELD_O = fd_o_r;
	assign HSYNC_OE = use_code | use_gen;
	assign VSYNC_OE = use_code | use_gen;
	assign FIELD_OE = use_code | use_gen;

	// ==========================================
	// ahb-lite slave
	assign take_w = HSEL & HTRANS[1] & HREADY & (HSIZE == 3'b010);
	assign wr_now = wr_pend_r;
	assign HREADYOUT = ~rd_pend_r;
	assign HRESP = 1'b0;
	assign HRDATA = hrdata_r;

	always @* begin
		case (addr_r)
			`VPSC_OFS_CTRL: rd_val = {24'h000000, ctrl_r};
			`VPSC_OFS_HFIRST: rd_val = {22'h000000, hf_r};
			`VPSC_OFS_HLAST: rd_val = {22'h000000, hl_r};
			`VPSC_OFS_VFIRST: rd_val = {22'h000000, vf_r};
			`VPSC_OFS_VLAST: rd_val = {22'h000000, vl_r};
			`VPSC_OFS_STATUS: rd_val = {28'h0000000, err_r, src_h, src_v, src_f};
			`VPSC_OFS_POS: rd_val = {6'h00, vline_r, 6'h00, hpos_r};
			default: rd_val = 32'h00000000;
		endcase
	end

	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 8'h00;
			hrdata_r <= 32'h00000000;
			ctrl_r <= `VPSC_CTRL_RST;
			hf_r <= `VPSC_HFIRST_RST;
			hl_r <= `VPSC_HLAST_RST;
			vf_r <= `VPSC_VFIRST_RST;
			vl_r <= `VPSC_VLAST_RST;
			err_r <= 1'b0;
		end else begin
			if (rd_pend_r) begin
				hrdata_r <= rd_val;
				rd_pend_r <= 1'b0;
			end
			wr_pend_r <= take_w & HWRITE;
			if (take_w) begin
				addr_r <= HADDR[7:0] & {8{HADDR[31:8] == 24'h000000}};
				rd_pend_r <= ~HWRITE;
				if (HADDR[31:8] != 24'h000000) begin
					addr_r <= 8'hff;
				end
			end
			if (wr_now) begin
				case (addr_r)
					`VPSC_OFS_CTRL: ctrl_r <= HWDATA[7:0];
					`VPSC_OFS_HFIRST: hf_r <= HWDATA[9:0];
					`VPSC_OFS_HLAST: hl_r <= HWDATA[9:0];
					`VPSC_OFS_VFIRST: vf_r <= HWDATA[9:0];
					`VPSC_OFS_VLAST: vl_r <= HWDATA[9:0];
					`VPSC_OFS_STATUS: begin
						if (HWDATA[`VPSC_STAT_ERR]) begin
							err_r <= 1'b0;
						end
					end
					default: begin
					end
				endcase
			end
			if (tc_err) begin
				err_r <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

//--- verif/vpsc_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks
module vpsc_chk (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic VID_DATA_OE,
	input wire logic HSYNC_OE,
	input wire logic VSYNC_OE,
	input wire logic FIELD_OE,
	input wire logic PORT_DIRECTION_PIN,
	input wire logic ACT_VALID,
	input wire logic ACT_CHROMA,
	input wire logic DEC_TAKE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	logic go_r, go_w, last_c_r;
	assign go_r = HSEL & HTRANS[1] & HREADY & !HWRITE & (HSIZE == 3'b010);
	assign go_w = HSEL & HTRANS[1] & HREADY & HWRITE & (HSIZE == 3'b010);
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B)
			last_c_r <= 1'b0;
		else if (ACT_VALID)
			last_c_r <= ACT_CHROMA;
	end
	a_resp_okay: assert property (HRESP == 1'b0) else $error("response not okay");
	a_oe_dir: assert property (VID_DATA_OE == !PORT_DIRECTION_PIN)
		else $error("data enable disagrees with direction");
	a_sync_oe_same: assert property (HSYNC_OE == VSYNC_OE && VSYNC_OE == FIELD_OE)
		else $error("sync enables differ");
	a_read_wait: assert property (go_r |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");
	a_write_zero: assert property (go_w |=> HREADYOUT) else $error("write stalled");
	a_rdata_hold: assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA))
		else $error("read data moved");
	a_act_pulse: assert property (ACT_VALID |=> !ACT_VALID) else $error("valid too long");
	a_act_enc: assert property (ACT_VALID |-> PORT_DIRECTION_PIN)
		else $error("capture while decoding");
	a_take_dec: assert property (DEC_TAKE |-> !PORT_DIRECTION_PIN && !$past(DEC_TAKE))
		else $error("take wrong");
	a_chroma_alt: assert property (ACT_VALID |-> ACT_CHROMA != last_c_r)
		else $error("chroma order wrong");
	c_read: cover property (go_r);
	c_act: cover property (ACT_VALID && ACT_CHROMA);
	c_take: cover property (DEC_TAKE);
endmodule

bind vpsc_top vpsc_chk u_vpsc_chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .VID_DATA_OE(VID_DATA_OE), .HSYNC_OE(HSYNC_OE),
	.VSYNC_OE(VSYNC_OE), .FIELD_OE(FIELD_OE), .PORT_DIRECTION_PIN(PORT_DIRECTION_PIN),
	.ACT_VALID(ACT_VALID), .ACT_CHROMA(ACT_CHROMA), .DEC_TAKE(DEC_TAKE));
`default_nettype wire

//--- verif/vpsc_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// video source model
module vpsc_src (
	output logic PIXEL_SAMPLE_CLOCK,
	output logic [7:0] VID_DATA_I,
	output logic HSYNC_I,
	output logic VSYNC_I,
	output logic FIELD_I
);
	initial begin
		PIXEL_SAMPLE_CLOCK = 1'b0;
		VID_DATA_I = 8'h00;
		HSYNC_I = 1'b1;
		VSYNC_I = 1'b1;
		FIELD_I = 1'b0;
	end
	function automatic logic [7:0] tcode(input logic f, input logic v, input logic h);
		return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
	endfunction
	task automatic put(input logic [7:0] b, input logic h);
		VID_DATA_I = b;
		HSYNC_I = h;
		#100 PIXEL_SAMPLE_CLOCK = 1'b1;
		#100 PIXEL_SAMPLE_CLOCK = 1'b0;
	endtask
	task automatic line(input logic v, input logic f, input logic bad, input logic [63:0] act);
		int i;
		VSYNC_I = v;
		FIELD_I = f;
		for (i = 0; i < 12; i++) begin
			if (i == 3 || i == 11)
				put(tcode(f, v, i == 3) ^ {7'h0, bad && i == 11}, 1'b1);
			else
				put((i == 0 || i == 8) ? 8'hff : (i < 4 || i > 8) ? 8'h00 : i[0] ? 8'h10 : 8'h80, 1'b1);
		end
		for (i = 0; i < 8; i++)
			put(act[63 - 8 * i -: 8], 1'b0);
		VID_DATA_I = ~VID_DATA_I;
	endtask
	task automatic run(input int n);
		repeat (n) put(~VID_DATA_I, HSYNC_I);
	endtask
endmodule
`default_nettype wire

//--- verif/vpsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "vpsc_regs.vh"
// ==========
// bench
module vpsc_top_tb;
	logic CORE_CLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP, PIXEL_SAMPLE_CLOCK, VID_DATA_OE;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [7:0] DEC_DATA, VID_DATA_I, VID_DATA_O, ACT_DATA, ctrl;
	logic HSYNC_I, HSYNC_O, HSYNC_OE, VSYNC_I, VSYNC_O, VSYNC_OE, FIELD_I, FIELD_O, FIELD_OE;
	logic PORT_DIRECTION_PIN, ACT_VALID, ACT_CHROMA, DEC_TAKE;
	logic [23:0] sh = 24'h0;
	logic [63:0] act;
	logic [8:0] exp_q [$];
	logic [7:0] modes [4] = '{8'h0b, 8'h03, 8'h29, 8'h20};
	int error_cnt = 0, cmp_count = 0, takes = 0, codes = 0;
	int pix = 0, eav_at = -1, exp_gap;
	logic dec_pend = 1'b0;
	logic [7:0] dec_exp = 8'h00;
	integer seed = 32'hcd6a79d9;
	vpsc_top u_vpsc_top (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.PIXEL_SAMPLE_CLOCK(PIXEL_SAMPLE_CLOCK), .VID_DATA_I(VID_DATA_I),
		.VID_DATA_O(VID_DATA_O), .VID_DATA_OE(VID_DATA_OE), .HSYNC_I(HSYNC_I),
		.HSYNC_O(HSYNC_O), .HSYNC_OE(HSYNC_OE), .VSYNC_I(VSYNC_I), .VSYNC_O(VSYNC_O),
		.VSYNC_OE(VSYNC_OE), .FIELD_I(FIELD_I), .FIELD_O(FIELD_O), .FIELD_OE(FIELD_OE),
		.PORT_DIRECTION_PIN(PORT_DIRECTION_PIN), .ACT_VALID(ACT_VALID), .ACT_DATA(ACT_DATA),
		.ACT_CHROMA(ACT_CHROMA), .DEC_DATA(DEC_DATA), .DEC_TAKE(DEC_TAKE));
	vpsc_src u_vpsc_src (.PIXEL_SAMPLE_CLOCK(PIXEL_SAMPLE_CLOCK), .VID_DATA_I(VID_DATA_I),
		.HSYNC_I(HSYNC_I), .VSYNC_I(VSYNC_I), .FIELD_I(FIELD_I));
	initial begin
		CORE_CLK = 1'b0;
		forever #12.5 CORE_CLK = ~CORE_CLK;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("mismatches %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(negedge CORE_CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 20);
		if (HREADYOUT !== 1'b1) begin
			check(HREADYOUT, 1'b1, "bus ready");
			end_of_test();
		end
		rd = HRDATA;
		@(posedge CORE_CLK);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		wait_rdy();
		HTRANS <= 2'b00;
		HWDATA <= d;
		wait_rdy();
		HSEL <= 1'b0;
	endtask
	always @(posedge CORE_CLK)
		DEC_DATA <= 8'h01 + 8'({$random(seed)} % 254);
	always @(negedge CORE_CLK) begin
		if (DEC_TAKE === 1'b1)
			takes++;
		if (dec_pend)
			check(VID_DATA_O, dec_exp, "dec byte");
		dec_pend = (DEC_TAKE === 1'b1);
		dec_exp = DEC_DATA;
		if (ACT_VALID === 1'b1)
			check({ACT_CHROMA, ACT_DATA}, exp_q.size() ? exp_q.pop_front() : 'x, "byte");
	end
	always @(posedge PIXEL_SAMPLE_CLOCK) begin
		pix++;
		if (sh == 24'hff0000) begin
			codes++;
			if (VID_DATA_O[4]) begin
				eav_at = pix;
			end else if (eav_at >= 0) begin
				exp_gap = (ctrl[2] ? `VPSC_LINE_LEN_625 : `VPSC_LINE_LEN_525) - `VPSC_ACT_BYTES - 4;
				check(pix - eav_at, exp_gap, "blank len");
			end
			check(VID_DATA_O, {1'b1, VID_DATA_O[6:4], VID_DATA_O[5] ^ VID_DATA_O[4],
				VID_DATA_O[6] ^ VID_DATA_O[4], VID_DATA_O[6] ^ VID_DATA_O[5],
				^VID_DATA_O[6:4]}, "code");
		end
		sh <= {sh[15:0], VID_DATA_O};
	end
	initial begin
		#1ms;
		check(0, 1, "timeout");
		end_of_test();
	end
	initial begin
		int m, l, i;
		RST_B = 1'b0;
		HSEL = 1'b0;
		HTRANS = 2'b00;
		HWRITE = 1'b0;
		HADDR = 32'h0;
		HSIZE = 3'b010;
		HWDATA = 32'h0;
		repeat (12) @(posedge CORE_CLK);
		RST_B <= 1'b1;
		@(negedge CORE_CLK);
		check({PORT_DIRECTION_PIN, VID_DATA_OE}, 2'b01, "reset dir");
		bus(1'b0, `VPSC_OFS_CTRL, 0);
		check(rd, 32'h02, "ctrl reset");
		bus(1'b0, `VPSC_OFS_HLAST, 0);
		check(rd, 32'h2cf, "hlast reset");
		bus(1'b0, `VPSC_OFS_VLAST, 0);
		check(rd, 32'hf2, "vlast reset");
		bus(1'b0, 8'h1c, 0);
		check(rd, 0, "unmapped");
		bus(1'b1, `VPSC_OFS_HFIRST, 2);
		bus(1'b1, `VPSC_OFS_HLAST, 3);
		bus(1'b1, `VPSC_OFS_VFIRST, 1);
		bus(1'b1, `VPSC_OFS_VLAST, 1);
		bus(1'b0, `VPSC_OFS_HLAST, 0);
		check(rd, 3, "hlast");
		for (m = 0; m < 4; m++) begin
			ctrl = modes[m];
			bus(1'b1, `VPSC_OFS_CTRL, {24'h0, ctrl});
			@(negedge CORE_CLK);
			check({PORT_DIRECTION_PIN, HSYNC_OE, VSYNC_OE, FIELD_OE}, {ctrl[0], {3{ctrl[1]}}},
				"dirs");
			takes = 0;
			for (l = -1; l < 3; l++) begin
				act = {$random(seed), $random(seed)};
				if (l == 1 && ctrl[0])
					for (i = 4; i < 8; i++)
						exp_q.push_back({!i[0], act[63 - 8 * i -: 8] ^ {ctrl[3] & !i[0], 7'h0}});
				u_vpsc_src.line(l < 0, m[0], m == 0 && l == 2, act);
				repeat (6) @(negedge CORE_CLK);
				if (ctrl[1])
					check({HSYNC_O, VSYNC_O, FIELD_O}, {m == 0 && l == 2, l < 0, m[0]}, "sync");
			end
			check(exp_q.size(), 0, "missing bytes");
			check(takes, ctrl[0] ? 0 : 4, "takes");
			if (m == 0) begin
				bus(1'b0, `VPSC_OFS_STATUS, 0);
				check(rd[3], 1'b1, "code err");
				bus(1'b1, `VPSC_OFS_STATUS, 32'h8);
				bus(1'b0, `VPSC_OFS_STATUS, 0);
				check(rd[3], 1'b0, "err clear");
			end
		end
		ctrl = 8'h02;
		bus(1'b1, `VPSC_OFS_CTRL, {24'h0, ctrl});
		codes = 0;
		u_vpsc_src.run(1800);
		check(codes >= 2, 1'b1, "codes seen");
		ctrl = 8'h06;
		bus(1'b1, `VPSC_OFS_CTRL, {24'h0, ctrl});
		codes = 0;
		u_vpsc_src.run(300);
		check(codes, 1, "codes 625");
		end_of_test();
	end
endmodule
`default_nettype wire
